// ---- hdl/hfc_pkg.sv ----
// constants, field layouts and carrier types for the field conditioning core
// assumes a 50 MHz system clock; shared by the core and its bench
package hfc_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int BIT_TIME_NS = 1000;
    localparam int BIT_CYC = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALF_CYC = BIT_CYC / 2;
    localparam int FRAME_BITS = 21;
    localparam int REPLY_BITS = 17;
    localparam int GAIN_FRAC = 6;
    localparam int OUT_MAX = 511;
    localparam int OUT_MIN = -512;
    localparam int SPAN_STEP_MT = 20;
    localparam logic [2:0] ADDR_GAIN_BIAS = 3'h0;
    localparam logic [2:0] ADDR_SHAPING = 3'h1;
    localparam logic [2:0] ADDR_PROD_A = 3'h2;
    localparam logic [2:0] ADDR_PROD_B = 3'h3;
    localparam logic [2:0] ADDR_READOUT = 3'h4;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_READ = 2'h2;
    localparam int BIAS_LSB = 0;
    localparam int GAIN_LSB = 8;
    localparam int SPAN_LSB = 0;
    localparam int TCL_LSB = 3;
    localparam int TCQ_LSB = 8;
    localparam int ALIGN_BIT = 13;
    localparam int FREEZE_BIT = 14;
    localparam logic [15:0] GAIN_BIAS_RST = 16'h4000;
    localparam logic [15:0] SHAPING_RST = 16'h0000;
    localparam logic [9:0] DIAG_CODE = 10'h000;
    localparam logic [9:0] MID_CODE = 10'h200;

    typedef enum {ST_IDLE, ST_START, ST_BITS, ST_EXEC, ST_REPLY} hfc_state_type;

    typedef struct packed {
        logic [1:0] cmd;
        logic [2:0] addr;
        logic [15:0] data;
    } hfc_frame_type;

    typedef struct packed {
        logic valid;
        logic conv_ovf;
        logic overtemp;
        logic signed [9:0] field;
    } hfc_sample_type;
endpackage

// ---- hdl/hfc_core.sv ----
// field conditioning core: offset/gain path, settings memory, supply-line command port
// assumes converter samples and status arrive synchronous to sys_clk; prog line is async
//
// Operation
// - gain is 8-bit, -2 to +127/64 in 1/64 steps; unity maps full scale to full scale
// - an 8-bit bias is subtracted in the adder, setting the zero-field output
// - alignment bit 1 scales bias over the full output range
// - alignment bit 0 scales bias over one quarter of full scale
// - 3-bit range code n selects plus/minus 20*(n+1) mT
// - 16-bit readback register holds the current processed value
// - only ten bits are valid, range -512 to 511
// - readback register is read-only; writes leave it alone
// - with unity gain, negative fields give positive readings
// - adder or multiplier overflow is an error
// - converter overflow and overtemperature are errors
// - any error forces the output into the lower diagnostic band
// - once lock is active, memory writes are refused
// - the lock bit can never be cleared by the customer
// - while unlocked, setting writes are accepted
// - commands arrive on the supply line; device answers on its output pin
// - four 16-bit customer memory words are exposed
// - second word holds range, two temperature coefficients, alignment and lock
// - third and fourth words hold production data, readable only
// - output equals gain times (negated input minus bias), both two's complement
// - lock takes effect only after the next power cycle
// - locked devices still answer reads with all contents
`timescale 1ns/1ps
module hfc_core #(
    // arbitrary production words, replaced per part
    parameter logic [15:0] PROD_INFO_A = 16'h5A5A,
    parameter logic [15:0] PROD_INFO_B = 16'hA5A5
) (
    // clock, resets, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic nvm_blank,
    input wire logic clk_en,
    // converter side
    input wire hfc_pkg::hfc_sample_type smp,
    output logic [2:0] field_span_sel,
    output logic [7:0] span_mt,
    output logic [4:0] temp_coef_linear,
    output logic [4:0] temp_coef_quad,
    // output stage
    output logic [9:0] out_code,
    output logic diag_level_band,
    output logic [15:0] processed_field_readout,
    // programming link
    input wire logic supply_prog_line,
    output logic reply_line,
    output logic reply_active,
    output logic customer_freeze_bit
);
    logic sync1_reg, sync2_reg, sync3_reg, line_reg, line_next;
    hfc_pkg::hfc_state_type state_reg, state_next;
    logic [5:0] cnt_reg, cnt_next;
    logic [4:0] idx_reg, idx_next;
    logic [20:0] shift_reg, shift_next;
    logic [16:0] rsh_reg, rsh_next;
    logic reply_reg, reply_next, ract_reg, ract_next;
    logic [15:0] gain_bias_reg, gain_bias_next, shaping_reg, shaping_next;
    logic lock_reg, lock_next, seen_reg, seen_next;
    logic [15:0] readout_reg, readout_next;
    logic [9:0] code_reg, code_next;
    logic diag_reg, diag_next;
    logic [7:0] span_reg, span_next;
    hfc_pkg::hfc_frame_type frm;
    logic [15:0] rd_value;
    logic signed [11:0] x_val, bias_val, diff;
    logic signed [19:0] prod, scaled;
    logic add_ovf, mul_ovf, any_err;
    default clocking cb_sys @(posedge sys_clk); endclocking
    default disable iff (rst);

    assign frm = shift_reg;

    // three-stage sync; a level is taken only once stages two and three agree
    always_comb begin
        line_next = line_reg;
        if (sync2_reg == sync3_reg) begin
            line_next = sync3_reg;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            sync3_reg <= 1'b1;
            line_reg <= 1'b1;
        end else if (clk_en) begin
            sync1_reg <= supply_prog_line;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            line_reg <= line_next;
        end
    end

    // signal path
    always_comb begin
        x_val = -$signed({{2{smp.field[9]}}, smp.field});
        if (shaping_reg[hfc_pkg::ALIGN_BIT]) begin
            bias_val = $signed({{2{gain_bias_reg[7]}}, gain_bias_reg[7:0], 2'b00});
        end else begin
            bias_val = $signed({{4{gain_bias_reg[7]}}, gain_bias_reg[7:0]});
        end
        diff = x_val - bias_val;
        prod = $signed(gain_bias_reg[15:8]) * diff;
        scaled = prod >>> hfc_pkg::GAIN_FRAC;
        add_ovf = (diff > hfc_pkg::OUT_MAX) || (diff < hfc_pkg::OUT_MIN);
        mul_ovf = (scaled > hfc_pkg::OUT_MAX) || (scaled < hfc_pkg::OUT_MIN);
        any_err = add_ovf || mul_ovf || smp.conv_ovf || smp.overtemp;
        readout_next = readout_reg;
        code_next = code_reg;
        diag_next = diag_reg;
        if (smp.valid) begin
            readout_next = {{6{scaled[9]}}, scaled[9:0]};
            diag_next = any_err;
            if (any_err) begin
                code_next = hfc_pkg::DIAG_CODE;
            end else begin
                code_next = scaled[9:0] ^ hfc_pkg::MID_CODE;
            end
        end
        span_next = 8'(hfc_pkg::SPAN_STEP_MT * (int'(shaping_reg[2:0]) + 1));
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            readout_reg <= 16'h0000;
            code_reg <= hfc_pkg::MID_CODE;
            diag_reg <= 1'b0;
            span_reg <= 8'h14;
        end else if (clk_en) begin
            readout_reg <= readout_next;
            code_reg <= code_next;
            diag_reg <= diag_next;
            span_reg <= span_next;
        end
    end

    // settings memory and lock; the memory keeps its content across rst (power cycle)
    always_comb begin
        gain_bias_next = gain_bias_reg;
        shaping_next = shaping_reg;
        if (state_reg == hfc_pkg::ST_EXEC && frm.cmd == hfc_pkg::CMD_WRITE && !lock_reg) begin
            if (frm.addr == hfc_pkg::ADDR_GAIN_BIAS) begin
                gain_bias_next = frm.data;
            end else if (frm.addr == hfc_pkg::ADDR_SHAPING) begin
                shaping_next = frm.data;
                shaping_next[hfc_pkg::FREEZE_BIT] = shaping_reg[hfc_pkg::FREEZE_BIT]
                    | frm.data[hfc_pkg::FREEZE_BIT];
            end
            // production words and the readback are never written
        end
        unique case (frm.addr)
            hfc_pkg::ADDR_GAIN_BIAS: rd_value = gain_bias_next;
            hfc_pkg::ADDR_SHAPING: rd_value = shaping_next;
            hfc_pkg::ADDR_PROD_A: rd_value = PROD_INFO_A;
            hfc_pkg::ADDR_PROD_B: rd_value = PROD_INFO_B;
            hfc_pkg::ADDR_READOUT: rd_value = readout_reg;
            default: rd_value = 16'h0000;
        endcase
        // lock is sampled once after power-up, so a freshly set bit waits for the next power cycle
        lock_next = lock_reg;
        seen_next = 1'b1;
        if (!seen_reg) begin
            lock_next = shaping_reg[hfc_pkg::FREEZE_BIT];
        end
    end

    always_ff @(posedge sys_clk or posedge nvm_blank) begin
        if (nvm_blank) begin
            gain_bias_reg <= hfc_pkg::GAIN_BIAS_RST;
            shaping_reg <= hfc_pkg::SHAPING_RST;
        end else if (clk_en) begin
            gain_bias_reg <= gain_bias_next;
            shaping_reg <= shaping_next;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lock_reg <= 1'b0;
            seen_reg <= 1'b0;
        end else if (clk_en) begin
            lock_reg <= lock_next;
            seen_reg <= seen_next;
        end
    end

    // command receiver and reply sender
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        idx_next = idx_reg;
        shift_next = shift_reg;
        rsh_next = rsh_reg;
        unique case (state_reg)
            hfc_pkg::ST_IDLE: begin
                cnt_next = 6'h00;
                if (!line_reg) begin
                    state_next = hfc_pkg::ST_START;
                end
            end
            hfc_pkg::ST_START: begin
                cnt_next = cnt_reg + 6'h01;
                if (cnt_reg == 6'(hfc_pkg::HALF_CYC - 1)) begin
                    cnt_next = 6'h00;
                    idx_next = 5'h00;
                    // a glitch shorter than half a bit is dropped
                    state_next = line_reg ? hfc_pkg::ST_IDLE : hfc_pkg::ST_BITS;
                end
            end
            hfc_pkg::ST_BITS: begin
                cnt_next = cnt_reg + 6'h01;
                if (cnt_reg == 6'(hfc_pkg::BIT_CYC - 1)) begin
                    cnt_next = 6'h00;
                    shift_next = {shift_reg[19:0], line_reg};
                    idx_next = idx_reg + 5'h01;
                    if (idx_reg == 5'(hfc_pkg::FRAME_BITS - 1)) begin
                        state_next = hfc_pkg::ST_EXEC;
                    end
                end
            end
            hfc_pkg::ST_EXEC: begin
                cnt_next = 6'h00;
                idx_next = 5'h00;
                rsh_next = {1'b1, rd_value};
                if (frm.cmd == hfc_pkg::CMD_READ || frm.cmd == hfc_pkg::CMD_WRITE) begin
                    state_next = hfc_pkg::ST_REPLY;
                end else begin
                    state_next = hfc_pkg::ST_IDLE;
                end
            end
            hfc_pkg::ST_REPLY: begin
                cnt_next = cnt_reg + 6'h01;
                if (cnt_reg == 6'(hfc_pkg::BIT_CYC - 1)) begin
                    cnt_next = 6'h00;
                    rsh_next = {rsh_reg[15:0], 1'b0};
                    idx_next = idx_reg + 5'h01;
                    if (idx_reg == 5'(hfc_pkg::REPLY_BITS - 1)) begin
                        state_next = hfc_pkg::ST_IDLE;
                    end
                end
            end
        endcase
        ract_next = (state_next == hfc_pkg::ST_REPLY);
        reply_next = ract_next && rsh_next[16];
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= hfc_pkg::ST_IDLE;
            cnt_reg <= 6'h00;
            idx_reg <= 5'h00;
            shift_reg <= 21'h000000;
            rsh_reg <= 17'h00000;
            reply_reg <= 1'b0;
            ract_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            idx_reg <= idx_next;
            shift_reg <= shift_next;
            rsh_reg <= rsh_next;
            reply_reg <= reply_next;
            ract_reg <= ract_next;
        end
    end

    assign field_span_sel = shaping_reg[hfc_pkg::SPAN_LSB +: 3];
    assign temp_coef_linear = shaping_reg[hfc_pkg::TCL_LSB +: 5];
    assign temp_coef_quad = shaping_reg[hfc_pkg::TCQ_LSB +: 5];
    assign span_mt = span_reg;
    assign out_code = code_reg;
    assign diag_level_band = diag_reg;
    assign processed_field_readout = readout_reg;
    assign reply_line = reply_reg;
    assign reply_active = ract_reg;
    assign customer_freeze_bit = lock_reg;
    property p_readout_only_samples;
        !(clk_en && smp.valid) |=> $stable(readout_reg);
    endproperty
    a_readout_only_samples: assert property (p_readout_only_samples)
        else $error("readback changed without a sample");
    property p_err_diag;
        clk_en && smp.valid && (smp.overtemp || smp.conv_ovf)
            |=> code_reg == hfc_pkg::DIAG_CODE && diag_reg;
    endproperty
    a_err_diag: assert property (p_err_diag)
        else $error("error did not force the diagnostic band");
    property p_sign_ext;
        readout_reg[15:9] == 7'h00 || readout_reg[15:9] == 7'h7F;
    endproperty
    a_sign_ext: assert property (p_sign_ext)
        else $error("readback not sign-extended");
    property p_lock_refuse;
        lock_reg && state_reg == hfc_pkg::ST_EXEC
            |=> $stable(gain_bias_reg) && $stable(shaping_reg);
    endproperty
    a_lock_refuse: assert property (p_lock_refuse)
        else $error("locked memory was written");
    property p_freeze_sticky;
        shaping_reg[hfc_pkg::FREEZE_BIT] |=> shaping_reg[hfc_pkg::FREEZE_BIT];
    endproperty
    a_freeze_sticky: assert property (p_freeze_sticky)
        else $error("lock bit was cleared");
    // span lags the range field by one cycle, so compare against last cycle's code
    property p_span;
        clk_en && !rst
            |=> span_reg == 8'(hfc_pkg::SPAN_STEP_MT * (int'($past(field_span_sel)) + 1));
    endproperty
    a_span: assert property (p_span)
        else $error("range decode wrong");
    property p_write_ok;
        clk_en && state_reg == hfc_pkg::ST_EXEC && !lock_reg && frm.cmd == hfc_pkg::CMD_WRITE
            && frm.addr == hfc_pkg::ADDR_GAIN_BIAS |=> gain_bias_reg == $past(frm.data);
    endproperty
    a_write_ok: assert property (p_write_ok)
        else $error("unlocked write not taken");
    property p_reply_start;
        clk_en && state_reg == hfc_pkg::ST_EXEC && frm.cmd == hfc_pkg::CMD_READ
            |=> reply_reg && ract_reg;
    endproperty
    a_reply_start: assert property (p_reply_start)
        else $error("read got no reply start bit");
    property p_unity;
        clk_en && smp.valid && !smp.conv_ovf && !smp.overtemp && gain_bias_reg == 16'h4000
            && smp.field == -10'sd511 |=> readout_reg == 16'h01FF && !diag_reg;
    endproperty
    a_unity: assert property (p_unity)
        else $error("unity gain full scale mismatch");
    property p_lock_hold;
        seen_reg |=> $stable(lock_reg);
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("lock changed before a power cycle");
    c_read: cover property (state_reg == hfc_pkg::ST_EXEC && frm.cmd == hfc_pkg::CMD_READ);
    c_write: cover property (state_reg == hfc_pkg::ST_EXEC && frm.cmd == hfc_pkg::CMD_WRITE);
    c_error: cover property (diag_reg);
    c_locked_write: cover property (state_reg == hfc_pkg::ST_EXEC && lock_reg);
endmodule

// ---- tb/hfc_programmer.sv ----
// partner model: external programmer that modulates the supply line
// assumes the core samples each bit near its middle and answers on reply_line
`timescale 1ns/1ps
module hfc_programmer (
    // clock
    input wire logic sys_clk,
    // answer from the core
    input wire logic reply_line,
    input wire logic reply_active,
    // modulated supply, idles high
    output logic supply_prog_line
);
    initial supply_prog_line = 1'b1;

    // sends one frame after gap idle cycles; got stays low when no answer comes
    task automatic transact(input logic [20:0] frame, input int gap,
                            output logic [15:0] rdata, output logic got);
        int n;
        rdata = 16'hFFFF;
        got = 1'b0;
        repeat (gap + 1) @(posedge sys_clk);
        supply_prog_line <= 1'b0;
        repeat (hfc_pkg::BIT_CYC) @(posedge sys_clk);
        for (int i = 20; i > 0; i--) begin
            supply_prog_line <= frame[i];
            repeat (hfc_pkg::BIT_CYC) @(posedge sys_clk);
        end
        supply_prog_line <= frame[0];
        n = 0;
        // the answer starts while the last bit is still on the line
        while (reply_active !== 1'b1 && n < 300) begin
            @(posedge sys_clk);
            if (n == hfc_pkg::BIT_CYC) supply_prog_line <= 1'b1;
            n++;
            #1;
        end
        if (reply_active === 1'b1) begin
            @(posedge sys_clk);
            supply_prog_line <= 1'b1;
            repeat (hfc_pkg::HALF_CYC - 1) @(posedge sys_clk);
            #1;
            got = (reply_line === 1'b1);
            for (int i = 15; i >= 0; i--) begin
                repeat (hfc_pkg::BIT_CYC) @(posedge sys_clk);
                #1;
                rdata[i] = reply_line;
            end
            n = 0;
            while (reply_active === 1'b1 && n < 100) begin
                @(posedge sys_clk);
                n++;
                #1;
            end
        end
    endtask
endmodule

// ---- tb/hfc_core_tb.sv ----
// self-checking bench for the field conditioning core
// assumes the programmer model in hfc_programmer.sv; rows first, then hand-written cases
`timescale 1ns/1ps
module hfc_core_tb;
    // arbitrary production words
    localparam logic [15:0] PROD_A = 16'h1234;
    localparam logic [15:0] PROD_B = 16'hC3C3;
    typedef struct packed {
        logic [15:0] gain_bias;
        logic [15:0] shaping;
        logic [9:0] field;
        logic ovf;
        logic ot;
        logic [15:0] readout;
        logic [9:0] code;
        logic diag;
    } hfc_row_type;
    localparam int NROWS = 11;
    hfc_row_type rows [NROWS] = '{
        '{16'h4000, 16'h0000, 10'h201, 1'b0, 1'b0, 16'h01FF, 10'h3FF, 1'b0},
        '{16'h4000, 16'h0000, 10'h1FF, 1'b0, 1'b0, 16'hFE01, 10'h001, 1'b0},
        '{16'h4010, 16'h0000, 10'h000, 1'b0, 1'b0, 16'hFFF0, 10'h1F0, 1'b0},
        '{16'h4010, 16'h2000, 10'h000, 1'b0, 1'b0, 16'hFFC0, 10'h1C0, 1'b0},
        '{16'h8000, 16'h0000, 10'h39C, 1'b0, 1'b0, 16'hFF38, 10'h138, 1'b0},
        '{16'h0100, 16'h0000, 10'h07F, 1'b0, 1'b0, 16'hFFFE, 10'h1FE, 1'b0},
        '{16'h7F00, 16'h0000, 10'h2D4, 1'b0, 1'b0, 16'h0000, 10'h000, 1'b1},
        '{16'h407F, 16'h2000, 10'h064, 1'b0, 1'b0, 16'h0000, 10'h000, 1'b1},
        '{16'h4000, 16'h0000, 10'h000, 1'b1, 1'b0, 16'h0000, 10'h000, 1'b1},
        '{16'h4000, 16'h0000, 10'h000, 1'b0, 1'b1, 16'h0000, 10'h000, 1'b1},
        '{16'h4000, 16'h0000, 10'h064, 1'b0, 1'b0, 16'hFF9C, 10'h19C, 1'b0}
    };
    logic sys_clk = 1'b0;
    logic rst;
    logic nvm_blank;
    logic clk_en;
    hfc_pkg::hfc_sample_type smp;
    logic [2:0] field_span_sel;
    logic [7:0] span_mt;
    logic [4:0] temp_coef_linear;
    logic [4:0] temp_coef_quad;
    logic [9:0] out_code;
    logic diag_level_band;
    logic [15:0] processed_field_readout;
    logic supply_prog_line;
    logic reply_line;
    logic reply_active;
    logic customer_freeze_bit;
    int miscompares = 0;
    int n_compared = 0;
    logic [15:0] gb_cur;
    logic [15:0] sh_cur;
    logic [15:0] r;
    logic g;

    always #10 sys_clk = ~sys_clk;

    hfc_core #(.PROD_INFO_A(PROD_A), .PROD_INFO_B(PROD_B)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .nvm_blank(nvm_blank), .clk_en(clk_en), .smp(smp),
        .field_span_sel(field_span_sel), .span_mt(span_mt),
        .temp_coef_linear(temp_coef_linear), .temp_coef_quad(temp_coef_quad),
        .out_code(out_code), .diag_level_band(diag_level_band),
        .processed_field_readout(processed_field_readout),
        .supply_prog_line(supply_prog_line), .reply_line(reply_line),
        .reply_active(reply_active), .customer_freeze_bit(customer_freeze_bit)
    );

    hfc_programmer u_prog (
        .sys_clk(sys_clk), .reply_line(reply_line), .reply_active(reply_active),
        .supply_prog_line(supply_prog_line)
    );

    task automatic give_verdict();
        if (miscompares == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask

    // one command frame; the answer always carries the register after the operation
    task automatic cmd(input logic [1:0] c, input logic [2:0] a, input logic [15:0] d,
                       input logic [15:0] exp);
        logic [15:0] rd;
        logic got;
        u_prog.transact({c, a, d}, 3, rd, got);
        chk({15'h0, got}, 16'h0001);
        chk(rd, exp);
    endtask

    task automatic sample(input logic [9:0] f, input logic ovf, input logic ot);
        @(posedge sys_clk);
        smp <= '{valid: 1'b1, conv_ovf: ovf, overtemp: ot, field: f};
        @(posedge sys_clk);
        smp.valid <= 1'b0;
        #1;
    endtask

    // a reset here stands for a power cycle; settings memory survives it
    task automatic power_cycle();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask

    initial begin
        repeat (95000) @(posedge sys_clk);
        miscompares++;
        give_verdict();
    end

    initial begin
        rst = 1'b1;
        nvm_blank = 1'b1;
        clk_en = 1'b1;
        smp = '0;
        repeat (7) @(posedge sys_clk);
        #1;
        chk({6'h0, out_code}, 16'h0200);
        chk(processed_field_readout, 16'h0000);
        chk({8'h0, span_mt}, 16'h0014);
        chk({13'h0, diag_level_band, reply_active, customer_freeze_bit}, 16'h0000);
        @(posedge sys_clk);
        rst <= 1'b0;
        nvm_blank <= 1'b0;
        repeat (4) @(posedge sys_clk);
        cmd(hfc_pkg::CMD_READ, hfc_pkg::ADDR_SHAPING, 16'h0, 16'h0000);
        gb_cur = 16'h4000;
        sh_cur = 16'h0000;
        for (int i = 0; i < NROWS; i++) begin
            if (rows[i].gain_bias !== gb_cur) begin
                gb_cur = rows[i].gain_bias;
                cmd(hfc_pkg::CMD_WRITE, hfc_pkg::ADDR_GAIN_BIAS, gb_cur, gb_cur);
            end
            if (rows[i].shaping !== sh_cur) begin
                sh_cur = rows[i].shaping;
                cmd(hfc_pkg::CMD_WRITE, hfc_pkg::ADDR_SHAPING, sh_cur, sh_cur);
            end
            sample(rows[i].field, rows[i].ovf, rows[i].ot);
            chk({6'h0, out_code}, {6'h0, rows[i].code});
            chk({15'h0, diag_level_band}, {15'h0, rows[i].diag});
            if (rows[i].diag === 1'b0) chk(processed_field_readout, rows[i].readout);
        end
        for (int k = 0; k < 8; k++) begin
            sh_cur = {3'b000, 5'(31 - k), 5'(k * 3), 3'(k)};
            cmd(hfc_pkg::CMD_WRITE, hfc_pkg::ADDR_SHAPING, sh_cur, sh_cur);
            chk({13'h0, field_span_sel}, 16'(k));
            chk({8'h0, span_mt}, 16'(20 * (k + 1)));
            chk({6'h0, temp_coef_quad, temp_coef_linear}, {6'h0, 5'(31 - k), 5'(k * 3)});
        end
        cmd(hfc_pkg::CMD_READ, hfc_pkg::ADDR_PROD_A, 16'h0, PROD_A);
        cmd(hfc_pkg::CMD_READ, 3'h5, 16'h0, 16'h0000);
        cmd(hfc_pkg::CMD_WRITE, hfc_pkg::ADDR_PROD_B, 16'h0000, PROD_B);
        sample(10'h39C, 1'b0, 1'b0);
        cmd(hfc_pkg::CMD_WRITE, hfc_pkg::ADDR_READOUT, 16'hBEEF, 16'h0064);
        chk(processed_field_readout, 16'h0064);
        cmd(hfc_pkg::CMD_READ, hfc_pkg::ADDR_READOUT, 16'h0, 16'h0064);
        // a slow programmer with an unknown command code gets no answer
        u_prog.transact({2'h3, hfc_pkg::ADDR_GAIN_BIAS, 16'h1111}, 200, r, g);
        chk({15'h0, g}, 16'h0000);
        cmd(hfc_pkg::CMD_WRITE, hfc_pkg::ADDR_SHAPING, 16'h4000, 16'h4000);
        chk({15'h0, customer_freeze_bit}, 16'h0000);
        cmd(hfc_pkg::CMD_WRITE, hfc_pkg::ADDR_GAIN_BIAS, 16'h4100, 16'h4100);
        power_cycle();
        chk({15'h0, customer_freeze_bit}, 16'h0001);
        cmd(hfc_pkg::CMD_WRITE, hfc_pkg::ADDR_GAIN_BIAS, 16'h4000, 16'h4100);
        cmd(hfc_pkg::CMD_READ, hfc_pkg::ADDR_SHAPING, 16'h0, 16'h4000);
        cmd(hfc_pkg::CMD_WRITE, hfc_pkg::ADDR_SHAPING, 16'h0000, 16'h4000);
        power_cycle();
        chk({15'h0, customer_freeze_bit}, 16'h0001);
        // a stopped clock enable must hold the readout through a sample
        @(posedge sys_clk);
        clk_en <= 1'b0;
        sample(10'h201, 1'b0, 1'b0);
        chk(processed_field_readout, 16'h0000);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        sample(10'h39C, 1'b0, 1'b0);
        chk(processed_field_readout, 16'h0065);
        give_verdict();
    end
endmodule
